// ==== verif/csmap_periph_model.sv ====
// csmap_periph_model.sv: peripheral behind select three, ends cycles by acknowledge.
// assumes a pull-up on the acknowledge line, so released means high.
module csmap_periph_model (
  input  wire       hclk,
  input  wire       select_line_three_n,
  input  wire [3:0] ta_delay,
  output logic      transfer_acknowledge_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // slow answers come from a larger delay
  always @(posedge hclk) begin
    if (select_line_three_n) begin
      cnt <= 0;
      transfer_acknowledge_n <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      // one-cycle acknowledge per beat; a held level would end the next cycle early
      transfer_acknowledge_n <= !(cnt == ta_delay);
    end
  end
endmodule

// ==== verif/csmap_sva.sv ====
// csmap_sva.sv: concurrent checks on the csmap_top ports.
// assumes one clock hclk and asynchronous active-low hresetn.
module csmap_sva (
  input wire       hclk,
  input wire       hresetn,
  input wire       ext_done,
  input wire [1:0] ext_size,
  input wire       ext_isram_hit,
  input wire       transfer_acknowledge_n,
  input wire       boot_select_line_n,
  input wire       select_line_one_n,
  input wire       select_line_two_n,
  input wire       select_line_three_n,
  input wire [3:0] byte_lane_n
);
  wire [3:0] sel_n = {select_line_three_n, select_line_two_n, select_line_one_n, boot_select_line_n};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_one_sel; $onehot0(~sel_n); endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_sel_hold; (sel_n != 4'hF && !ext_done) |=> $stable(sel_n); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved mid cycle");
  property p_isram; ext_done && ext_isram_hit |-> sel_n == 4'hF; endproperty
  a_isram: assert property (p_isram) else $error("select on internal hit");
  property p_ta; ext_done && !select_line_three_n |-> !$past(transfer_acknowledge_n, 3); endproperty
  a_ta: assert property (p_ta) else $error("peripheral ended without ack");
  // flash waits are 3 programmed or 14 in boot mode
  property p_flash_wait; $fell(boot_select_line_n) |-> !ext_done[*3] ##[1:13] ext_done; endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash wait count");
  property p_sram_wait; $fell(select_line_one_n) |-> ##1 ext_done; endproperty
  a_sram_wait: assert property (p_sram_wait) else $error("sram not zero wait");
  property p_lane_byte; !select_line_one_n && ext_size == 2'h0 |-> $onehot(~byte_lane_n); endproperty
  a_lane_byte: assert property (p_lane_byte) else $error("byte lanes");
  property p_lane_word; (!select_line_one_n || !boot_select_line_n) && ext_size == 2'h2 |-> byte_lane_n == 4'h0;
  endproperty
  a_lane_word: assert property (p_lane_word) else $error("word lanes");
  c_ta: cover property (ext_done && !select_line_three_n);
  c_boot: cover property ($fell(boot_select_line_n));
  c_isram: cover property (ext_done && ext_isram_hit);
endmodule
bind csmap_top csmap_sva i_sva (.hclk(hclk), .hresetn(hresetn), .ext_done(ext_done), .ext_size(ext_size),
  .ext_isram_hit(ext_isram_hit), .transfer_acknowledge_n(transfer_acknowledge_n),
  .boot_select_line_n(boot_select_line_n), .select_line_one_n(select_line_one_n),
  .select_line_two_n(select_line_two_n), .select_line_three_n(select_line_three_n), .byte_lane_n(byte_lane_n));

// ==== verif/test_csmap_top.sv ====
// test_csmap_top.sv: self-checking bench for the chip-select decoder.
// assumes hready looped from hreadyout, one peripheral model on select three.
module test_csmap_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_req = 0, ext_write = 0, vec = 0;
  logic [31:0] haddr = 0, hwdata = 0, ext_addr = 0, hrdata, rvec, d;
  logic [1:0]  htrans = 0, ext_size = 0;
  logic [3:0]  ta_delay = 4'h1, lanes_n;
  wire         rdy, hresp, done, err, ish, ifh, ta_n, s0, s1, s2, s3;
  int          miscompares = 0, total_checks = 0;
  logic [31:0] rst_v [8] = '{32'h0080_0003, 32'hFFE0_0030, 32'hFFF0_0003, 32'hFFF0_0000, 32'h0, 32'h0,
                             32'h0100_0807, 32'hFFFF_80F0};
  always #12.5 hclk = ~hclk;
  csmap_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hrdata(hrdata),
    .hresp(hresp), .ext_req(ext_req), .ext_addr(ext_addr), .ext_write(ext_write), .ext_size(ext_size),
    .ext_burst(1'b0), .ext_done(done), .ext_err(err), .ext_isram_hit(ish), .ext_iflash_hit(ifh),
    .transfer_acknowledge_n(ta_n), .vector_location_bit(vec), .boot_select_line_n(s0),
    .select_line_one_n(s1), .select_line_two_n(s2), .select_line_three_n(s3), .byte_lane_n(lanes_n),
    .reset_vector(rvec));
  csmap_periph_model i_periph (.hclk(hclk), .select_line_three_n(s3), .ta_delay(ta_delay),
    .transfer_acknowledge_n(ta_n));
  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rdy_wait;
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (rdy === 1'b1) break;
    end
    if (n == 50) begin
      chk(0, 1, "bus hang");
      test_done;
    end
  endtask
  // bus cycle: address phase, then data phase; read data taken at its closing edge
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy_wait;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy_wait;
    d = hrdata;
  endtask
  // external cycle: expected select set, error and latency in falling-edge counts (0 = any)
  task automatic ext(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [3:0] esel,
                     input logic e, input int lat);
    int n;
    logic [3:0] seen;
    seen = 4'h0;
    ext_req <= 1;
    ext_addr <= a;
    ext_write <= w;
    ext_size <= sz;
    for (n = 1; n < 5000; n++) begin
      @(negedge hclk);
      seen |= ~{s3, s2, s1, s0};
      if (done === 1'b1) break;
    end
    if (n == 5000) begin
      chk(0, 1, "ext hang");
      test_done;
    end
    chk(seen, esel, "select");
    chk(err, e, "error");
    if (lat > 0) chk(n, lat, "latency");
    @(posedge hclk);
    ext_req <= 0;
    @(posedge hclk);
  endtask
  task automatic sc_reset;
    for (int i = 0; i < 8; i++) begin
      ahb(0, i * 4, 0);
      chk(d, rst_v[i], "region reset");
    end
    ahb(0, 32'h030, 0);
    chk(d, 0, "unmapped");
    chk(hresp, 0, "okay response");
    ahb(0, 32'h020, 0);
    chk(d, 32'h003F_8003, "config reset");
    chk(rvec, 32'h0000_0100, "vector low");
  endtask
  task automatic sc_boot;
    ext(32'hFFF0_0000, 0, 2, 4'h1, 0, 17);
    ext(32'h2000_0000, 0, 0, 4'h1, 0, 17);
    ahb(1, 32'h004, 32'hFFE0_0030);
    ahb(1, 32'h020, 32'h003F_8003);
  endtask
  task automatic sc_map;
    ext(32'h0080_0000, 0, 2, 4'h1, 0, 6);
    ext(32'h009F_FFFC, 0, 2, 4'h1, 0, 6);
    ext(32'h0080_0002, 0, 1, 4'h1, 0, 6);
    ext(32'h0080_0000, 1, 2, 4'h1, 0, 6);
    ext(32'h0080_0000, 1, 1, 4'h0, 1, 2);
    ext(32'hFFF0_0000, 0, 2, 4'h2, 0, 3);
    ext(32'hFFF8_0001, 1, 0, 4'h2, 0, 3);
    ext(32'hFFFF_FFFE, 1, 1, 4'h2, 0, 3);
    ext(32'h0100_0000, 0, 1, 4'h8, 0, 7);
    ta_delay <= 4'h9;
    ext(32'h0100_7FF0, 1, 1, 4'h8, 0, 15);
    ext(32'h0100_8000, 0, 2, 4'h0, 1, 2);
    ext(32'h2000_0000, 0, 2, 4'h0, 1, 2);
  endtask
  task automatic sc_inner;
    ext(32'h003F_8000, 0, 2, 4'h0, 0, 2);
    chk(ish, 1, "isram hit");
    ext(32'h0000_0000, 0, 2, 4'h0, 0, 2);
    chk(ifh, 1, "iflash hit");
    ahb(1, 32'h020, 32'h0040_0002);
    ext(32'h0040_0000, 0, 2, 4'h0, 0, 2);
    chk(ish, 1, "moved isram");
    ext(32'h003F_8000, 0, 2, 4'h0, 1, 2);
    ext(32'h0000_0000, 0, 2, 4'h0, 1, 2);
    chk(ifh, 0, "iflash off");
  endtask
  task automatic sc_revec;
    vec <= 1;
    hresetn <= 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    repeat (6) @(posedge hclk);
    chk(rvec, 32'hFFF0_0100, "vector high");
    ext(32'h0080_0000, 0, 2, 4'h1, 0, 17);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    repeat (6) @(posedge hclk);
    sc_reset;
    sc_boot;
    sc_map;
    sc_inner;
    sc_revec;
    test_done;
  end
endmodule

// ==== verilog/csmap_defines.vh ====
// csmap_defines.vh: register offsets, field positions, reset values and timing counts of the
// chip-select decoder. Assumes inclusion by bare name from the design files.
`ifndef CSMAP_DEFINES_VH
`define CSMAP_DEFINES_VH
// register byte offsets on the AHB-Lite slave
`define CSMAP_OFF_R0_BASE   12'h000
`define CSMAP_OFF_R0_OPT    12'h004
`define CSMAP_OFF_R1_BASE   12'h008
`define CSMAP_OFF_R1_OPT    12'h00C
`define CSMAP_OFF_R2_BASE   12'h010
`define CSMAP_OFF_R2_OPT    12'h014
`define CSMAP_OFF_R3_BASE   12'h018
`define CSMAP_OFF_R3_OPT    12'h01C
`define CSMAP_OFF_CONFIG    12'h020
`define CSMAP_OFF_STATUS    12'h024
`define CSMAP_OFF_DECODE    12'h028
`define CSMAP_OFF_RESULT    12'h02C
// base register fields
`define CSMAP_BASE_VALID    0
`define CSMAP_BASE_PS_LO    1
`define CSMAP_BASE_PS_HI    2
`define CSMAP_BASE_TAEXT    11
// option register fields
`define CSMAP_OPT_WS_LO     4
`define CSMAP_OPT_WS_HI     7
`define CSMAP_OPT_MASK_LO   15
// port size codes
`define CSMAP_PS_32         2'b01
`define CSMAP_PS_16         2'b11
// external-terminate wait-state code
`define CSMAP_WS_EXT        4'hF
// reset values of the region registers
`define CSMAP_R0_BASE_RST   32'h0080_0003
`define CSMAP_R0_OPT_RST    32'hFFE0_0030
`define CSMAP_R1_BASE_RST   32'hFFF0_0003
`define CSMAP_R1_OPT_RST    32'hFFF0_0000
`define CSMAP_R2_BASE_RST   32'h0000_0000
`define CSMAP_R2_OPT_RST    32'h0000_0000
`define CSMAP_R3_BASE_RST   32'h0100_0807
`define CSMAP_R3_OPT_RST    32'hFFFF_80F0
// config register fields
`define CSMAP_CFG_INTERNAL_FLASH_ENABLE      0
`define CSMAP_CFG_SRAM_SEL  1
`define CSMAP_CFG_FLSH_SEL  2
`define CSMAP_CFG_VECT      3
`define CSMAP_CFG_ISR_LO    8
`define CSMAP_CFG_RST       32'h0000_0003
// internal memory placement, reset vector addresses and sram half split
`define CSMAP_ISRAM_BASE    32'h003F_8000
`define CSMAP_ISRAM_TOP     32'h0000_8FFF
`define CSMAP_IFLASH_TOP    32'h000F_FFFF
`define CSMAP_VEC_LOW       32'h0000_0100
`define CSMAP_VEC_HIGH      32'hFFF0_0100
`define CSMAP_SRAM_HALF     19
// timing
`define CSMAP_TIMEOUT_CYC   16'h1000
`endif

// ==== verilog/csmap_region.v ====
// csmap_region.v: one programmable address region compare.
// Assumes base and option words held stable by the register file.
`include "csmap_defines.vh"
module csmap_region (
  base_reg,
  opt_reg,
  addr,
  hit
);
  input  wire [31:0] base_reg;
  input  wire [31:0] opt_reg;
  input  wire [31:0] addr;
  output wire        hit;

  wire [31:0] mask;
  // mask bits below the field are don't-care
  assign mask = {opt_reg[31:`CSMAP_OPT_MASK_LO], {`CSMAP_OPT_MASK_LO{1'b0}}};
  assign hit = base_reg[`CSMAP_BASE_VALID] & (((addr ^ base_reg) & mask) == 32'h0000_0000);
endmodule

// ==== verilog/csmap_top.v ====
// csmap_top.v: chip-select decoder with four regions, boot select and internal memory map.
// Assumes one AHB-Lite master, an external cycle requester, and board devices behind the
// select lines; transfer_acknowledge_n and vector strap come from pins.
// Functional notes
// - flash bank is 32-bit; writes only full words, reads any width; the code checks write width only on select zero.
// - async flash accesses and a burst's first beat take programmed wait states; in boot mode the code uses 14 instead.
// - sram pair decoded linearly: lower half first device, upper half second; the code drives one select for the whole sram range.
// - sram bank is 32-bit, byte, half and word reads and writes by lanes.
// - internal sram at default base, data space, relocatable on 32 KB boundaries.
// - internal flash of sixteen 64 KB blocks silent when its enable is zero.
// - four programmable regions with active-low selects zero to three; zero boots.
// - default decode: flash 0x0080_0000, peripheral 0x0100_0000, sram 0xFFF0_0000 up.
// - peripheral region 16-bit, base 0x0100_0807, ends only on transfer acknowledge; the code also ends it with an error on the 0x1000 timeout.
// - routing switches: sram on select zero or one, flash zero or two, peripheral three.
// - reset fetch starts at 0x100 if vector bit zero, else 0xFFF0_0100.
// - after reset select zero answers every address until its option is written; the code drives no select on internal hits or narrow writes outside region 1.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`include "csmap_defines.vh"
module csmap_top (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hrdata,
  hresp,
  ext_req,
  ext_addr,
  ext_write,
  ext_size,
  ext_burst,
  ext_done,
  ext_err,
  ext_isram_hit,
  ext_iflash_hit,
  transfer_acknowledge_n,
  vector_location_bit,
  boot_select_line_n,
  select_line_one_n,
  select_line_two_n,
  select_line_three_n,
  byte_lane_n,
  reset_vector
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output wire        hreadyout;
  output reg  [31:0] hrdata;
  output wire        hresp;
  input  wire        ext_req;
  input  wire [31:0] ext_addr;
  input  wire        ext_write;
  input  wire [1:0]  ext_size;
  input  wire        ext_burst;
  output reg         ext_done;
  output reg         ext_err;
  output reg         ext_isram_hit;
  output reg         ext_iflash_hit;
  input  wire        transfer_acknowledge_n;
  input  wire        vector_location_bit;
  output reg         boot_select_line_n;
  output reg         select_line_one_n;
  output reg         select_line_two_n;
  output reg         select_line_three_n;
  output reg  [3:0]  byte_lane_n;
  output reg  [31:0] reset_vector;

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_TA   = 2'd2;

  reg  [31:0] base_r [0:3];
  reg  [31:0] opt_r  [0:3];
  reg  [31:0] config_r;
  reg         global_boot;
  reg  [1:0]  ta_sync;
  reg  [1:0]  vec_sync;
  reg  [1:0]  vec_age;
  reg         dp_act;
  reg         dp_wr;
  reg  [11:0] dp_off;
  reg  [1:0]  state;
  reg  [3:0]  wait_cnt;
  reg  [15:0] ta_cnt;
  reg  [3:0]  cur_sel;
  reg  [1:0]  last_reg;
  reg  [31:0] next_rdata;
  wire [3:0]  hit;
  wire        take;
  wire        ta_n;
  wire        vec_pin;

  assign ta_n = ta_sync[1];
  assign vec_pin = vec_sync[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel & hready & htrans[1];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
      csmap_region u_region (
        .base_reg (base_r[gi]),
        .opt_reg  (opt_r[gi]),
        .addr     (ext_addr),
        .hit      (hit[gi])
      );
    end
  endgenerate

  // routed bank select: select zero carries sram or flash per switches
  reg  [3:0]  sel_vec;
  reg  [1:0]  hit_reg;
  reg         any_hit;
  reg  [1:0]  ps;
  reg  [3:0]  ws;
  reg         taext;
  reg         size_ok;
  reg  [3:0]  lanes;
  always @* begin
    sel_vec = 4'h0;
    hit_reg = 2'd0;
    any_hit = 1'b0;
    if (global_boot) begin
      any_hit = 1'b1;
    end else if (hit[0]) begin
      any_hit = 1'b1;
    end else if (hit[1]) begin
      any_hit = 1'b1;
      hit_reg = 2'd1;
    end else if (hit[2]) begin
      any_hit = 1'b1;
      hit_reg = 2'd2;
    end else if (hit[3]) begin
      any_hit = 1'b1;
      hit_reg = 2'd3;
    end
    // sram on one, flash on two unless the switches park them on zero
    case (hit_reg)
      2'd1: sel_vec = config_r[`CSMAP_CFG_SRAM_SEL] ? 4'b0010 : 4'b0001;
      2'd2: sel_vec = config_r[`CSMAP_CFG_FLSH_SEL] ? 4'b0100 : 4'b0001;
      2'd3: sel_vec = 4'b1000;
      default: sel_vec = 4'b0001;
    endcase
    if (!any_hit) begin
      sel_vec = 4'h0;
    end
    ps = base_r[hit_reg][`CSMAP_BASE_PS_HI:`CSMAP_BASE_PS_LO];
    ws = opt_r[hit_reg][`CSMAP_OPT_WS_HI:`CSMAP_OPT_WS_LO];
    taext = base_r[hit_reg][`CSMAP_BASE_TAEXT] | (ws == `CSMAP_WS_EXT);
    // writes on select zero take words only unless region 1 hits; sram takes any width
    size_ok = 1'b1;
    if (ext_write && (ext_size != 2'd2) && (sel_vec == 4'b0001) && !hit[1]) begin
      size_ok = 1'b0;
    end
    case (ext_size)
      2'd0: lanes = 4'b0001 << ext_addr[1:0];
      2'd1: lanes = ext_addr[1] ? 4'b1100 : 4'b0011;
      default: lanes = 4'b1111;
    endcase
    if (ps == `CSMAP_PS_16) begin
      lanes = lanes & 4'b0011;
    end
  end

  wire [31:0] isram_base;
  wire        isram_hit;
  wire        iflash_hit;
  assign isram_base = {config_r[31:15], 15'h0000};
  assign isram_hit = ((ext_addr - isram_base) <= `CSMAP_ISRAM_TOP);
  assign iflash_hit = config_r[`CSMAP_CFG_INTERNAL_FLASH_ENABLE] & (ext_addr <= `CSMAP_IFLASH_TOP);

  // external cycle engine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      wait_cnt <= 4'h0;
      ta_cnt <= 16'h0000;
      cur_sel <= 4'h0;
      last_reg <= 2'd0;
      ext_done <= 1'b0;
      ext_err <= 1'b0;
      ext_isram_hit <= 1'b0;
      ext_iflash_hit <= 1'b0;
      boot_select_line_n <= 1'b1;
      select_line_one_n <= 1'b1;
      select_line_two_n <= 1'b1;
      select_line_three_n <= 1'b1;
      byte_lane_n <= 4'hF;
    end else begin
      ext_done <= 1'b0;
      ext_err <= 1'b0;
      case (state)
        ST_IDLE: begin
          // ext_req still stands in the cycle of the done pulse; do not take it twice
          if (ext_req && !ext_done) begin
            ext_isram_hit <= isram_hit;
            ext_iflash_hit <= iflash_hit;
            last_reg <= hit_reg;
            if (isram_hit || iflash_hit) begin
              ext_done <= 1'b1;
            end else if (!any_hit || !size_ok) begin
              ext_done <= 1'b1;
              ext_err <= 1'b1;
            end else begin
              cur_sel <= sel_vec;
              boot_select_line_n <= ~sel_vec[0];
              select_line_one_n <= ~sel_vec[1];
              select_line_two_n <= ~sel_vec[2];
              select_line_three_n <= ~sel_vec[3];
              byte_lane_n <= ~lanes;
              ta_cnt <= 16'h0000;
              if (taext) begin
                state <= ST_TA;
              end else begin
                // burst first beat and async single both get the full delay
                wait_cnt <= global_boot ? `CSMAP_WS_EXT - 4'h1 : ws;
                state <= ST_WAIT;
              end
            end
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 4'h0) begin
            ext_done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        ST_TA: begin
          // a dead peripheral would hang the bus; bound the wait
          ta_cnt <= ta_cnt + 16'h0001;
          if (!ta_n || (ta_cnt == `CSMAP_TIMEOUT_CYC)) begin
            ext_done <= 1'b1;
            ext_err <= ta_n;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (ext_done || state == ST_IDLE && !ext_req) begin
        if (state == ST_IDLE) begin
          boot_select_line_n <= 1'b1;
          select_line_one_n <= 1'b1;
          select_line_two_n <= 1'b1;
          select_line_three_n <= 1'b1;
          byte_lane_n <= 4'hF;
        end
      end
    end
  end

  // pin synchronisers and strap capture after release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ta_sync <= 2'b11;
      vec_sync <= 2'b00;
      vec_age <= 2'd0;
      reset_vector <= `CSMAP_VEC_LOW;
    end else begin
      ta_sync <= {ta_sync[0], transfer_acknowledge_n};
      vec_sync <= {vec_sync[0], vector_location_bit};
      if (vec_age != 2'd3) begin
        vec_age <= vec_age + 2'd1;
      end
      // strap read only once it has crossed both sync stages
      if (vec_age == 2'd2) begin
        reset_vector <= vec_pin ? `CSMAP_VEC_HIGH : `CSMAP_VEC_LOW;
      end
    end
  end

  // register file
  integer ri;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_r[0] <= `CSMAP_R0_BASE_RST;
      opt_r[0] <= `CSMAP_R0_OPT_RST;
      base_r[1] <= `CSMAP_R1_BASE_RST;
      opt_r[1] <= `CSMAP_R1_OPT_RST;
      base_r[2] <= `CSMAP_R2_BASE_RST;
      opt_r[2] <= `CSMAP_R2_OPT_RST;
      base_r[3] <= `CSMAP_R3_BASE_RST;
      opt_r[3] <= `CSMAP_R3_OPT_RST;
      config_r <= `CSMAP_CFG_RST | `CSMAP_ISRAM_BASE;
      global_boot <= 1'b1;
      dp_act <= 1'b0;
      dp_wr <= 1'b0;
      dp_off <= 12'h000;
    end else begin
      dp_act <= take;
      if (take) begin
        dp_wr <= hwrite;
        dp_off <= haddr[11:0];
      end
      if (dp_act && dp_wr) begin
        for (ri = 0; ri < 4; ri = ri + 1) begin
          if (dp_off == ri * 8) begin
            base_r[ri] <= hwdata;
          end
          if (dp_off == ri * 8 + 4) begin
            opt_r[ri] <= hwdata;
          end
        end
        if (dp_off == `CSMAP_OFF_R0_OPT) begin
          global_boot <= 1'b0;
        end
        if (dp_off == `CSMAP_OFF_CONFIG) begin
          config_r <= {hwdata[31:15], 11'h000, hwdata[3:0]};
        end
      end
    end
  end

  // read mux, data out of a flop in the data phase
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr[11:0])
      `CSMAP_OFF_R0_BASE: next_rdata = base_r[0];
      `CSMAP_OFF_R0_OPT:  next_rdata = opt_r[0];
      `CSMAP_OFF_R1_BASE: next_rdata = base_r[1];
      `CSMAP_OFF_R1_OPT:  next_rdata = opt_r[1];
      `CSMAP_OFF_R2_BASE: next_rdata = base_r[2];
      `CSMAP_OFF_R2_OPT:  next_rdata = opt_r[2];
      `CSMAP_OFF_R3_BASE: next_rdata = base_r[3];
      `CSMAP_OFF_R3_OPT:  next_rdata = opt_r[3];
      `CSMAP_OFF_CONFIG:  next_rdata = config_r;
      `CSMAP_OFF_STATUS:  next_rdata = {25'h0, vec_pin, state, global_boot, ~ta_n, last_reg};
      `CSMAP_OFF_RESULT:  next_rdata = {28'h0, cur_sel};
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end
endmodule
